// [mbox_port_pkg.sv]
// package: constants, carrier structs and decode helpers for the four-port address and mailbox logic
// Functional notes
// - counter readback low drives counter onto address
// - counter readback wins over mask readback
// - readbacks ignore the chip enables
// - readback with chip enabled floats data lines
// - readback valid after one idle cycle
// - mask readback low drives mask onto address
// - wrap flag low one cycle on wrap
// - top four locations are the mailboxes
// - other port write asserts mailbox interrupt
// - owner read of mailbox releases interrupt
// - counter load takes address pins
// - counter increment advances by one
// - mask load from address, beats counter load
// - counter clear zeroes counter, below master reset
package mbox_port_pkg;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 18;
  localparam int NUM_PORTS = 4;

  // register byte addresses on the AXI4-Lite slave
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFF_MBOX_LVL = 8'h08;
  localparam logic [7:0] OFF_CNT_BASE = 8'h10;

  // status / mask field positions
  localparam int ST_WRAP_LSB = 0;
  localparam int ST_MBOX_LSB = 4;
  localparam int ST_W        = 8;

  // values after reset
  localparam logic [ST_W-1:0]   IRQ_MASK_RST = 8'h00;
  localparam logic [ADDR_W-1:0] MASK_RST     = 16'hFFFF;
  localparam logic [ADDR_W-1:0] CNT_RST      = 16'h0000;

  // readback pipeline: request edge, one idle cycle, then the value
  localparam int RB_IDLE_CYCLES = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RB_NONE = 2'b00,
    RB_CNT  = 2'b01,
    RB_MASK = 2'b10
  } rb_sel_e;

  // pins arriving at one port
  typedef struct packed {
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] io_in;
    logic              chip_select_low_active;
    logic              chip_select_high_active;
    logic              rw_n;
    logic              oe_n;
    logic              counter_load_n;
    logic              counter_increment_n;
    logic              mask_load_n;
    logic              counter_clear_n;
    logic              counter_readback_n;
    logic              mask_readback_n;
  } port_in_s;

  // pins leaving one port
  typedef struct packed {
    logic [ADDR_W-1:0] addr_out;
    logic              addr_oe;
    logic [DATA_W-1:0] io_out;
    logic              io_oe;
    logic              counter_wrap_flag_n;
    logic              mailbox_int_n;
  } port_out_s;

  // mailbox location of a port: the four top addresses, port index 0 lowest
  function automatic logic [ADDR_W-1:0] mbox_addr(input int unsigned port);
    mbox_addr = {{(ADDR_W-2){1'b1}}, port[1:0]};
  endfunction : mbox_addr

  // both chip enables in their active states
  function automatic logic chip_on(input port_in_s p);
    chip_on = ~p.chip_select_low_active & p.chip_select_high_active;
  endfunction : chip_on

endpackage : mbox_port_pkg

// [port_addr_unit.sv]
// port address unit: burst counter, mask register, readback and wrap flag
`timescale 1ns/100ps
module port_addr_unit
  import mbox_port_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          master_reset_n,
  input  wire port_in_s      pin,
  output logic [AW-1:0]      cur_addr,
  output logic [AW-1:0]      rb_addr,
  output logic               rb_oe,
  output logic               rb_active,
  output logic               counter_wrap_flag_n,
  output logic               wrap_pulse
);

  logic [AW-1:0] cnt_ff;
  logic [AW-1:0] mask_ff;
  logic [AW-1:0] nxt_cnt;
  logic [AW-1:0] nxt_mask;
  logic [AW-1:0] rb_addr_ff;
  logic          rb_oe_ff;
  logic          wrap_ff;
  rb_sel_e       rb_req_ff;
  rb_sel_e       rb_req;
  logic [AW-1:0] cnt_inc;
  logic          wrap_now;

  // counter readback outranks mask readback, chip enables not consulted
  assign rb_req = !pin.counter_readback_n ? RB_CNT :
                  !pin.mask_readback_n    ? RB_MASK : RB_NONE;
  assign rb_active = (rb_req != RB_NONE) || (rb_req_ff != RB_NONE);

  // only masked bits count, so the burst wraps inside the mask window
  assign cnt_inc  = (cnt_ff & ~mask_ff) | ((cnt_ff + 1'b1) & mask_ff);
  assign wrap_now = !pin.counter_increment_n && ((cnt_ff & mask_ff) == mask_ff);

  // priority: master reset, clear, mask load, counter load, increment
  assign nxt_cnt  = !master_reset_n          ? CNT_RST[AW-1:0] :
                    !pin.counter_clear_n     ? CNT_RST[AW-1:0] :
                    !pin.mask_load_n         ? cnt_ff :
                    !pin.counter_load_n      ? pin.addr_in[AW-1:0] :
                    !pin.counter_increment_n ? cnt_inc : cnt_ff;
  assign nxt_mask = !master_reset_n          ? MASK_RST[AW-1:0] :
                    !pin.counter_clear_n     ? mask_ff :
                    !pin.mask_load_n         ? pin.addr_in[AW-1:0] : mask_ff;

  // counter and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= CNT_RST[AW-1:0];
      mask_ff <= MASK_RST[AW-1:0];
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      mask_ff <= nxt_mask;
    end
  end

  // wrap flag: one registered low cycle after the wrapping edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_ff <= 1'b0;
    end else if (ce) begin
      wrap_ff <= wrap_now && master_reset_n && pin.counter_clear_n
                 && pin.mask_load_n && pin.counter_load_n;
    end
  end

  // readback: request edge, idle cycle, then value from the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_req_ff  <= RB_NONE;
      rb_oe_ff   <= 1'b0;
      rb_addr_ff <= CNT_RST[AW-1:0];
    end else if (ce) begin
      rb_req_ff  <= rb_req;
      rb_oe_ff   <= (rb_req_ff != RB_NONE) && (rb_req != RB_NONE);
      rb_addr_ff <= (rb_req_ff == RB_CNT) ? cnt_ff : mask_ff;
    end
  end

  assign cur_addr            = cnt_ff;
  assign rb_addr             = rb_addr_ff;
  assign rb_oe               = rb_oe_ff;
  assign counter_wrap_flag_n = ~wrap_ff;
  assign wrap_pulse          = wrap_ff;

endmodule : port_addr_unit

// [mbox_port_top.sv]
// top: four port address units, mailbox flags and AXI4-Lite status registers
`timescale 1ns/100ps
module mbox_port_top
  import mbox_port_pkg::*;
#(
  parameter int NP = NUM_PORTS,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic                 master_reset_n,
  input  wire port_in_s  [NP-1:0]   port_in,
  output port_out_s      [NP-1:0]   port_out,
  output logic                      irq,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  logic [AW-1:0]   cur_addr  [NP];
  logic [AW-1:0]   rb_addr   [NP];
  logic [NP-1:0]   rb_oe;
  logic [NP-1:0]   rb_active;
  logic [NP-1:0]   wrap_n;
  logic [NP-1:0]   wrap_pulse;
  logic [NP-1:0]   acc_on;
  logic [NP-1:0]   wr_hit    [NP];
  logic [NP-1:0]   own_rd;
  logic [NP-1:0]   other_wr;
  logic [NP-1:0]   any_wr;
  logic [DW-1:0]   wr_data   [NP];
  logic [DW-1:0]   mbox_ff   [NP];
  logic [NP-1:0]   int_ff;
  logic [NP-1:0]   nxt_int;
  logic [DW-1:0]   rd_data_ff [NP];
  logic [NP-1:0]   rd_ff;
  logic [ST_W-1:0] status_ff;
  logic [ST_W-1:0] mask_ff;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] st_clr;

  // per-port address units and mailbox decode
  genvar gp;
  genvar gq;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      port_addr_unit #(.AW(AW)) u_addr (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .ce                  (ce),
        .master_reset_n      (master_reset_n),
        .pin                 (port_in[gp]),
        .cur_addr            (cur_addr[gp]),
        .rb_addr             (rb_addr[gp]),
        .rb_oe               (rb_oe[gp]),
        .rb_active           (rb_active[gp]),
        .counter_wrap_flag_n (wrap_n[gp]),
        .wrap_pulse          (wrap_pulse[gp])
      );

      // an array access needs the chip selected and no readback under way
      assign acc_on[gp] = chip_on(port_in[gp]) && !rb_active[gp];
      assign own_rd[gp] = acc_on[gp] && port_in[gp].rw_n
                          && (cur_addr[gp] == mbox_addr(gp));

      // wr_hit[target][writer]: writer port stores into target's mailbox
      for (gq = 0; gq < NP; gq++) begin : g_wr
        assign wr_hit[gp][gq] = acc_on[gq] && !port_in[gq].rw_n
                                && (cur_addr[gq] == mbox_addr(gp));
      end

      assign other_wr[gp] = |(wr_hit[gp] & ~(NP'(1) << gp));
      assign any_wr[gp]   = |wr_hit[gp];
      // set wins over the owner's clear in the same cycle
      assign nxt_int[gp]  = other_wr[gp] | (int_ff[gp] & ~own_rd[gp]);

      // data lines float during readback when the chip is selected
      assign port_out[gp].addr_out            = rb_addr[gp];
      assign port_out[gp].addr_oe             = rb_oe[gp];
      assign port_out[gp].io_out              = rd_data_ff[gp];
      assign port_out[gp].io_oe               = rd_ff[gp] && !port_in[gp].oe_n
                                                && !(rb_active[gp] && chip_on(port_in[gp]));
      assign port_out[gp].counter_wrap_flag_n = wrap_n[gp];
      assign port_out[gp].mailbox_int_n       = ~int_ff[gp];

      assign events[ST_WRAP_LSB+gp] = wrap_pulse[gp];
      assign events[ST_MBOX_LSB+gp] = other_wr[gp];
    end
  endgenerate

  // lowest-numbered writer wins when two ports collide on one mailbox
  always_comb begin
    for (int t = 0; t < NP; t++) begin
      wr_data[t] = '0;
      for (int w = NP-1; w >= 0; w--) begin
        if (wr_hit[t][w]) begin
          wr_data[t] = port_in[w].io_in;
        end
      end
    end
  end

  // mailbox storage, interrupt flags and read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_ff <= '0;
      rd_ff  <= '0;
      for (int i = 0; i < NP; i++) begin
        mbox_ff[i]    <= '0;
        rd_data_ff[i] <= '0;
      end
    end else if (ce) begin
      int_ff <= master_reset_n ? nxt_int : '0;
      rd_ff  <= '0;
      for (int i = 0; i < NP; i++) begin
        if (any_wr[i]) begin
          mbox_ff[i] <= wr_data[i];
        end
        // a port may read any mailbox; only its own read clears its flag
        for (int j = 0; j < NP; j++) begin
          if (acc_on[i] && port_in[i].rw_n && cur_addr[i] == mbox_addr(j)) begin
            rd_ff[i]      <= 1'b1;
            rd_data_ff[i] <= mbox_ff[j];
          end
        end
      end
    end
  end

  // AXI4-Lite slave
  logic        aw_got_ff;
  logic        wstrb0_ff;
  logic        w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic        wr_go;
  logic        rd_go;
  logic        st_rd;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;
  logic        cnt_hit;
  logic [1:0]  cnt_idx;

  assign s_axi_awready = ce && !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_got_ff && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  // read decode; counter words sit one per port above the base
  assign cnt_idx = s_axi_araddr[3:2];
  assign cnt_hit = (s_axi_araddr[7:4] == OFF_CNT_BASE[7:4]) && (32'(cnt_idx) < NP);
  assign st_rd   = rd_go && (s_axi_araddr == OFF_STATUS);
  assign rd_mux  = (s_axi_araddr == OFF_STATUS)   ? 32'(status_ff) :
                   (s_axi_araddr == OFF_IRQ_MASK) ? 32'(mask_ff) :
                   (s_axi_araddr == OFF_MBOX_LVL) ? 32'(int_ff) :
                   cnt_hit                        ? 32'(cur_addr[cnt_idx]) : 32'h0000_0000;
  assign rd_resp = ((s_axi_araddr == OFF_STATUS) || (s_axi_araddr == OFF_IRQ_MASK)
                    || (s_axi_araddr == OFF_MBOX_LVL) || cnt_hit) ? RESP_OKAY : RESP_SLVERR;

  // read of status clears it, but a same-cycle event still lands
  assign st_clr = st_rd ? status_ff : '0;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff == OFF_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // sticky status and interrupt mask; only byte lane 0 is meaningful
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= '0;
      mask_ff   <= IRQ_MASK_RST;
    end else if (ce) begin
      status_ff <= (status_ff & ~st_clr) | events;
      if (wr_go && awaddr_ff == OFF_IRQ_MASK && wstrb0_ff) begin
        mask_ff <= wdata_ff[ST_W-1:0];
      end
    end
  end

  // lane 0 strobe kept with the captured data, since aw and w may arrive apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstrb0_ff <= 1'b0;
    end else if (ce && s_axi_wvalid && s_axi_wready) begin
      wstrb0_ff <= s_axi_wstrb[0];
    end
  end

  assign irq = |(status_ff & mask_ff);

endmodule : mbox_port_top

// [port_ctrl_model.sv]
// partner model: external controller driving the pins of one port
`timescale 1ns/100ps
module port_ctrl_model
  import mbox_port_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic [5:0]        ctl,
  input  wire logic              chip,
  input  wire logic              wr,
  input  wire logic [ADDR_W-1:0] val,
  output port_in_s               pin
);
  logic              rb;
  logic [ADDR_W-1:0] last_ff;
  // ctl bits: load, increment, mask load, clear, counter readback, mask readback
  assign rb = ctl[1] | ctl[0];
  // undriven lines show the inverse of the last value so stale data never matches
  always_comb begin
    pin = '0;
    pin.chip_select_low_active = ~chip;
    pin.chip_select_high_active = chip;
    pin.rw_n = ~wr;
    pin.addr_in = (ctl[5] | ctl[3]) ? val : ~last_ff;
    pin.io_in = wr ? DATA_W'(val) : ~DATA_W'(last_ff);
    pin.counter_load_n = ~(ctl[5] & ~rb);
    pin.counter_increment_n = ~(ctl[4] & ~rb);
    pin.mask_load_n = ~(ctl[3] & ~rb);
    pin.counter_clear_n = ~(ctl[2] & ~rb);
    pin.counter_readback_n = ~ctl[1];
    pin.mask_readback_n = ~ctl[0];
  end
  // remember what was last put on the lines
  always_ff @(posedge aclk) last_ff <= val;
endmodule : port_ctrl_model

// [mbox_port_top_assertions.sv]
// checker: readback, flag and read-answer timing at the top ports
`timescale 1ns/100ps
module mbox_port_checker
  import mbox_port_pkg::*;
#(
  parameter int NP = NUM_PORTS
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               master_reset_n,
  input wire port_in_s [NP-1:0]  port_in,
  input wire port_out_s [NP-1:0] port_out,
  input wire logic [7:0]         s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [NP-1:0] rq, wr, rd, ow;
  // per-port readback request, write, own read and other-port write terms
  for (genvar i = 0; i < NP; i++) begin : g_t
    assign rq[i] = ~(port_in[i].counter_readback_n & port_in[i].mask_readback_n);
    assign wr[i] = chip_on(port_in[i]) & ~port_in[i].rw_n;
    assign rd[i] = chip_on(port_in[i]) & port_in[i].rw_n;
    assign ow[i] = |(wr & ~(NP'(1) << i));
  end
  property p_rb_on(i); rq[i] ##1 rq[i] |=> port_out[i].addr_oe; endproperty
  property p_rb_need(i); port_out[i].addr_oe |-> $past(rq[i]) && $past(rq[i], 2); endproperty
  property p_float(i);
    rq[i] && chip_on(port_in[i]) |-> !port_out[i].io_oe;
  endproperty
  property p_wrap(i);
    !port_out[i].counter_wrap_flag_n |->
      $past(!port_in[i].counter_increment_n) ##1 port_out[i].counter_wrap_flag_n;
  endproperty
  property p_mset(i); $fell(port_out[i].mailbox_int_n) |-> $past(ow[i]); endproperty
  property p_mclr(i);
    $rose(port_out[i].mailbox_int_n) && $past(master_reset_n) |-> $past(rd[i]);
  endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_unmap;
    s_axi_arvalid && s_axi_arready &&
      !(s_axi_araddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C})
      |=> s_axi_rresp == RESP_SLVERR;
  endproperty
  // per-port checks
  for (genvar i = 0; i < NP; i++) begin : g_a
    a_rb_on: assert property (p_rb_on(i)) else $error("readback not driven");
    a_rb_need: assert property (p_rb_need(i)) else $error("address driven early");
    a_float: assert property (p_float(i)) else $error("data not floated");
    a_wrap: assert property (p_wrap(i)) else $error("wrap flag width");
    a_mset: assert property (p_mset(i)) else $error("mailbox flag cause");
    a_mclr: assert property (p_mclr(i)) else $error("mailbox release cause");
  end
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  c_wrap: cover property (!port_out[0].counter_wrap_flag_n);
  c_mbox: cover property ($fell(port_out[3].mailbox_int_n));
  c_rb: cover property (port_out[0].addr_oe && chip_on(port_in[0]));
endmodule : mbox_port_checker

bind mbox_port_top mbox_port_checker #(.NP(NP)) mbox_port_checker_inst (.aclk, .aresetn,
  .master_reset_n, .port_in, .port_out, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rresp, .s_axi_rvalid);

// [mbox_port_top_tb.sv]
// testbench: pin-level port tests and register tests of the four-port block
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module mbox_port_top_tb;
  import mbox_port_pkg::*;
  logic aclk = '0, aresetn = '0, master_reset_n = '0, irq;
  logic [5:0] ctl [4] = '{default: '0};
  logic [3:0] chip = '0, wr = '0;
  logic [15:0] val [4] = '{default: '0};
  wire port_in_s [3:0] port_in;
  port_out_s [3:0] port_out;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0, n_checks = 0;
  // ce and byte strobes stay on: freezing is outside this block's rules
  mbox_port_top mbox_port_top_inst (.aclk, .aresetn, .ce(1'h1), .master_reset_n, .port_in,
    .port_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // one controller model per port
  for (genvar p = 0; p < 4; p++) begin : g_m
    port_ctrl_model port_ctrl_model_inst (.aclk, .ctl(ctl[p]), .chip(chip[p]), .wr(wr[p]),
      .val(val[p]), .pin(port_in[p]));
  end
  always #20 aclk = ~aclk;
  // hold a pin pattern on port p for n sampling edges
  task automatic drv(input int p, input logic [5:0] c, input logic ch, input logic w,
                     input logic [15:0] v, input int n);
    @(posedge aclk);
    ctl[p] <= c;
    chip[p] <= ch;
    wr[p] <= w;
    val[p] <= v;
    repeat (n - 1) @(posedge aclk);
  endtask : drv
  // readback held for three sampling edges (request, value and one hold edge), then checked after the third
  task automatic rb(input int p, input logic [5:0] c, input logic ch, input logic [15:0] e);
    drv(p, c, ch, '0, '0, 3);
    drv(p, '0, '0, '0, '0, 1);
    @(negedge aclk);
    `CHK(port_out[p].addr_oe, 1'h1)
    `CHK(port_out[p].addr_out, e)
    `CHK(port_out[p].io_oe, 1'h0)
  endtask : rb
  // ready is looked at before the edge that takes the item
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw = '0, w = '0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw |= s_axi_awready;
      w |= s_axi_wready;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, er)
    @(posedge aclk);
    s_axi_bready <= '0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= '0;
    do @(negedge aclk); while (!s_axi_rvalid);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
    @(posedge aclk);
    s_axi_rready <= '0;
  endtask : axr
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= '1;
    master_reset_n <= '1;
    axr(8'h04, 32'h0, RESP_OKAY);
    axr(8'h0C, 32'h0, RESP_SLVERR);
    axw(8'h08, 32'h1, RESP_SLVERR);
    rb(0, 6'h01, '0, MASK_RST);
    drv(0, 6'h20, '0, '0, 16'h0005, 1);
    drv(0, 6'h28, '0, '0, 16'h000F, 1);
    rb(0, 6'h03, '1, 16'h0005);
    rb(0, 6'h01, '1, 16'h000F);
    // each port's mailbox written by its neighbour, then read by its owner
    for (int p = 0; p < 4; p++) begin
      drv((p + 1) % 4, 6'h20, '0, '0, 16'hFFFC | 16'(p), 1);
      drv((p + 1) % 4, 6'h00, '1, '1, 16'hA500 | 16'(p), 1);
      drv((p + 1) % 4, '0, '0, '0, '0, 1);
      @(negedge aclk);
      `CHK(port_out[p].mailbox_int_n, 1'h0)
      `CHK(port_out[(p + 2) % 4].mailbox_int_n, 1'h1)
      axr(8'h08, 32'h1 << p, RESP_OKAY);
      drv(p, 6'h20, '0, '0, 16'hFFFC | 16'(p), 1);
      drv(p, 6'h00, '1, '0, '0, 1);
      drv(p, '0, '0, '0, '0, 1);
      @(negedge aclk);
      `CHK(port_out[p].mailbox_int_n, 1'h1)
      `CHK(port_out[p].io_out, {2'h0, 16'hA500 | 16'(p)})
      `CHK(port_out[p].io_oe, 1'h1)
    end
    drv(2, 6'h20, '0, '0, 16'hFFFE, 1);
    drv(2, 6'h00, '1, '1, 16'h0BAD, 1);
    drv(2, '0, '0, '0, '0, 1);
    @(negedge aclk);
    `CHK(port_out[2].mailbox_int_n, 1'h1)
    // own read answered while a readback starts with the chip on: data must float
    drv(2, 6'h00, '1, '0, '0, 1);
    drv(2, 6'h02, '1, '0, '0, 1);
    @(negedge aclk);
    `CHK(port_out[2].io_oe, 1'h0)
    `CHK(port_out[2].io_out, {2'h0, 16'h0BAD})
    drv(2, '0, '0, '0, '0, 1);
    @(negedge aclk);
    `CHK(irq, 1'h0)
    axw(8'h04, 32'hF0, RESP_OKAY);
    repeat (2) @(negedge aclk);
    `CHK(irq, 1'h1)
    axr(8'h00, 32'hF0, RESP_OKAY);
    repeat (2) @(negedge aclk);
    `CHK(irq, 1'h0)
    // masked counter: 000E, 000F, then wrap to zero
    drv(0, 6'h20, '0, '0, 16'h000E, 1);
    drv(0, 6'h10, '0, '0, '0, 1);
    drv(0, '0, '0, '0, '0, 1);
    axr(8'h10, 32'h000F, RESP_OKAY);
    drv(0, 6'h10, '0, '0, '0, 1);
    drv(0, '0, '0, '0, '0, 1);
    @(negedge aclk);
    `CHK(port_out[0].counter_wrap_flag_n, 1'h0)
    @(negedge aclk);
    `CHK(port_out[0].counter_wrap_flag_n, 1'h1)
    axr(8'h10, 32'h0, RESP_OKAY);
    axr(8'h00, 32'h01, RESP_OKAY);
    drv(1, 6'h20, '0, '0, 16'h0007, 1);
    drv(1, 6'h04, '0, '0, '0, 1);
    drv(1, '0, '0, '0, '0, 1);
    axr(8'h14, 32'h0, RESP_OKAY);
    drv(1, 6'h20, '0, '0, 16'h0005, 1);
    drv(1, 6'h08, '0, '0, 16'h00FF, 1);
    drv(1, '0, '0, '0, '0, 1);
    @(posedge aclk);
    master_reset_n <= '0;
    @(posedge aclk);
    master_reset_n <= '1;
    axr(8'h14, 32'h0, RESP_OKAY);
    rb(1, 6'h01, '0, MASK_RST);
    report_and_stop();
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
endmodule : mbox_port_top_tb
